// ==== emi_core.sv ====
// Purpose: Address generation, space decode and pin sequencing for data moves
// Assumes: Core holds the request stable while busy; one request per start pulse
// Notes:   Registers are reached through the core's special register port
`timescale 1ns/1ps
module emi_core
	import emi_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,
	// Special register port
	input  wire logic        sfr_wr_in,
	input  wire logic [7:0]  sfr_addr_in,
	input  wire logic [7:0]  sfr_wdata_in,
	output logic      [7:0]  sfr_rdata_out,
	// Move request
	input  wire logic        move_start_in,
	input  wire emi_req_t    move_req_in,
	output logic             move_busy_out,
	output logic             move_done_out,
	output logic      [7:0]  move_rdata_out,
	// Port latches and pin inputs
	input  wire emi_pins_t   port_latch_in,
	input  wire logic [7:0]  data_pins_in,
	input  wire logic [7:0]  port_output_mode_in,
	// Lower and upper port groups
	output emi_pins_t        low_pins_out,
	output emi_oe_t          low_oe_out,
	output emi_pins_t        high_pins_out,
	output emi_oe_t          high_oe_out,
	output logic      [7:0]  pin_output_mode_out,
	output logic             low_bus_claim_out
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ONCHIP, ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD, ST_DONE
	} emi_state_t;

	emi_state_t  state_r;
	logic [7:0]  onchip_data_ram_page_select_r;
	logic [7:0]  ext_mem_config_r;
	logic [7:0]  timing_r;
	emi_req_t    req_r;
	logic [4:0]  cnt_r;
	logic [7:0]  rdata_r;
	logic        done_r;
	logic [15:0] eff_addr;
	logic        offchip;
	logic        drive_upper;
	logic        mux_mode_select;
	logic        port_bank_select;
	emi_mode_t   mode;
	logic [7:0]  onchip_data_ram_rdata;
	logic        onchip_data_ram_we;
	emi_pins_t   pins;
	emi_oe_t     oe;
	logic        claim;

	// Config fields; a set mux bit selects separate address and data pins
	assign mode             = emi_mode_t'(ext_mem_config_r[CFG_MODE_HI:CFG_MODE_LO]);
	assign mux_mode_select  = !ext_mem_config_r[CFG_MUX_BIT]; // RULE_12
	assign port_bank_select = ext_mem_config_r[CFG_BANK_BIT];

	// Register writes
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			onchip_data_ram_page_select_r <= PAGE_RESET;
			ext_mem_config_r   <= CONFIG_RESET; // RULE_04
			timing_r           <= TIMING_RESET;
		end else if (sfr_wr_in) begin
			if (sfr_addr_in == PAGE_SEL_ADDR) begin
				onchip_data_ram_page_select_r <= sfr_wdata_in;
			end
			if (sfr_addr_in == CONFIG_ADDR) begin
				ext_mem_config_r <= sfr_wdata_in;
			end
			if (sfr_addr_in == TIMING_ADDR) begin
				timing_r <= sfr_wdata_in;
			end
		end
	end

	// Register readback
	always_comb begin
		unique case (sfr_addr_in)
			PAGE_SEL_ADDR: sfr_rdata_out = onchip_data_ram_page_select_r;
			CONFIG_ADDR:   sfr_rdata_out = ext_mem_config_r;
			TIMING_ADDR:   sfr_rdata_out = timing_r;
			default:       sfr_rdata_out = 8'h00;
		endcase
	end

	// Effective address and space decode
	always_comb begin
		if (move_req_in.wide) begin
			eff_addr = move_req_in.data_pointer; // RULE_02
		end else begin
			eff_addr = {onchip_data_ram_page_select_r, move_req_in.indirect_low}; // RULE_01 RULE_11
		end
		unique case (mode)
			EMI_MODE_ONCHIP:       offchip = 1'b0; // RULE_17
			EMI_MODE_SPLIT_NOBANK: offchip = (eff_addr >= 16'(ONCHIP_DATA_RAM_BYTES)); // RULE_19
			EMI_MODE_SPLIT_BANK:   offchip = (eff_addr >= 16'(ONCHIP_DATA_RAM_BYTES)); // RULE_20
			EMI_MODE_OFFCHIP:      offchip = 1'b1; // RULE_21
		endcase
		if (move_req_in.wide) begin
			drive_upper = 1'b1; // RULE_19
		end else begin
			drive_upper = (mode == EMI_MODE_SPLIT_BANK); // RULE_20 RULE_21
		end
	end

	// Latched request; in mode 11 the register form drops the page byte
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			req_r <= '0;
		end else if (state_r == ST_IDLE && move_start_in) begin
			req_r              <= move_req_in;
			req_r.data_pointer <= {(drive_upper ? eff_addr[15:8] : 8'h00), eff_addr[7:0]}; // RULE_21
			req_r.wide         <= drive_upper;
		end
	end

	// Sequencer; off-chip total is 4 + setup + strobe + hold (+2 min ALE)
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_r <= ST_IDLE;
			cnt_r   <= ZERO_CYCLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (move_start_in) begin
						if (!offchip) begin
							state_r <= ST_ONCHIP; // RULE_23
						end else if (mux_mode_select) begin
							state_r <= ST_ALE_HI;
							cnt_r   <= 5'(ext_mem_config_r[CFG_ALE_HI:CFG_ALE_LO]);
						end else begin
							state_r <= ST_SETUP;
							cnt_r   <= BASE_CYCLES - ONE_CYCLE - ONE_CYCLE - ONE_CYCLE
								+ 5'(timing_r[TM_SETUP_HI:TM_SETUP_LO]); // RULE_22
						end
					end
				end
				ST_ONCHIP: state_r <= ST_DONE;
				ST_ALE_HI: begin
					if (cnt_r == ZERO_CYCLE) begin
						state_r <= ST_ALE_LO;
						cnt_r   <= 5'(ext_mem_config_r[CFG_ALE_HI:CFG_ALE_LO]);
					end else begin
						cnt_r <= cnt_r - ONE_CYCLE;
					end
				end
				ST_ALE_LO: begin
					if (cnt_r == ZERO_CYCLE) begin
						state_r <= ST_SETUP;
						cnt_r   <= BASE_CYCLES - ONE_CYCLE - ONE_CYCLE - ONE_CYCLE
							+ 5'(timing_r[TM_SETUP_HI:TM_SETUP_LO]); // RULE_22
					end else begin
						cnt_r <= cnt_r - ONE_CYCLE;
					end
				end
				ST_SETUP: begin
					if (cnt_r == ZERO_CYCLE) begin
						state_r <= ST_STROBE;
						cnt_r   <= 5'(timing_r[TM_STRB_HI:TM_STRB_LO]);
					end else begin
						cnt_r <= cnt_r - ONE_CYCLE;
					end
				end
				ST_STROBE: begin
					if (cnt_r == ZERO_CYCLE) begin
						state_r <= ST_HOLD;
						cnt_r   <= 5'(timing_r[TM_HOLD_HI:TM_HOLD_LO]);
					end else begin
						cnt_r <= cnt_r - ONE_CYCLE;
					end
				end
				ST_HOLD: begin
					if (cnt_r == ZERO_CYCLE) begin
						state_r <= ST_DONE;
					end else begin
						cnt_r <= cnt_r - ONE_CYCLE;
					end
				end
				ST_DONE: state_r <= ST_IDLE;
			endcase
		end
	end

	// On-chip RAM, address wrapped modulo 8 k
	assign onchip_data_ram_we = (state_r == ST_IDLE) && move_start_in && !offchip && move_req_in.write;
	emi_onchip_data_ram #(
		.DEPTH (ONCHIP_DATA_RAM_BYTES),
		.AW    (ONCHIP_DATA_RAM_AW)
	) u_onchip_data_ram (
		.core_clk_in (core_clk_in),
		.we_in       (onchip_data_ram_we),
		.addr_in     (eff_addr[ONCHIP_DATA_RAM_AW-1:0]), // RULE_18 RULE_03
		.wdata_in    (move_req_in.wdata),
		.rdata_out   (onchip_data_ram_rdata)
	);

	// Read data capture and completion pulse
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			rdata_r <= 8'h00;
			done_r  <= 1'b0;
		end else begin
			done_r <= (state_r == ST_DONE);
			if (state_r == ST_ONCHIP) begin
				rdata_r <= onchip_data_ram_rdata;
			end else if (state_r == ST_STROBE && cnt_r == ZERO_CYCLE && !req_r.write) begin
				rdata_r <= data_pins_in;
			end
		end
	end
	assign move_busy_out  = (state_r != ST_IDLE);
	assign move_done_out  = done_r;
	assign move_rdata_out = rdata_r;

	// Bus pin values and enables while claimed
	assign claim = (state_r inside {ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD}); // RULE_07 RULE_23
	always_comb begin
		pins         = port_latch_in; // RULE_07
		oe           = '1;
		if (claim) begin
			pins.addr_hi     = req_r.data_pointer[15:8];
			pins.ale         = (state_r == ST_ALE_HI); // RULE_14
			pins.rd_n        = !((state_r == ST_STROBE) && !req_r.write);
			pins.wr_n        = !((state_r == ST_STROBE) && req_r.write);
			oe.ctrl_oe_n     = 1'b0;
			oe.addr_hi_oe_n  = !req_r.wide; // RULE_19 RULE_21
			if (mux_mode_select) begin
				// Shared pins: address first, then data
				pins.data    = (state_r == ST_ALE_HI) ? req_r.data_pointer[7:0] : req_r.wdata; // RULE_13 RULE_14
				oe.data_oe_n = !((state_r == ST_ALE_HI) || req_r.write); // RULE_08
			end else begin
				pins.addr_lo    = req_r.data_pointer[7:0]; // RULE_16
				pins.data       = req_r.wdata;
				oe.addr_lo_oe_n = 1'b0;
				oe.data_oe_n    = !req_r.write; // RULE_08
			end
		end
	end

	// Route to the selected port group
	always_comb begin
		low_pins_out  = port_latch_in;
		high_pins_out = port_latch_in;
		low_oe_out    = '1;
		high_oe_out   = '1;
		if (port_bank_select) begin
			high_pins_out = pins; // RULE_05
			high_oe_out   = oe;
		end else begin
			low_pins_out  = pins;
			low_oe_out    = oe;
		end
	end
	assign low_bus_claim_out   = claim && !port_bank_select; // RULE_06
	assign pin_output_mode_out = port_output_mode_in; // RULE_09
endmodule

// ==== emi_core_properties.sv ====
// Purpose: Port-level checker for the move sequencer
// Assumes: Request held stable while busy
// Notes:   Shadows the config register from register writes
`timescale 1ns/1ps
module emi_core_props
	import emi_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       reset_in,
	input  wire logic       sfr_wr_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       move_start_in,
	input  wire emi_req_t   move_req_in,
	input  wire logic       move_busy_out,
	input  wire logic       move_done_out,
	input  wire logic [7:0] port_output_mode_in,
	input  wire emi_pins_t  low_pins_out,
	input  wire emi_oe_t    low_oe_out,
	input  wire emi_oe_t    high_oe_out,
	input  wire logic [7:0] pin_output_mode_out,
	input  wire logic       low_bus_claim_out
);
	logic [7:0] cfg_r;
	logic [1:0] mode;
	logic       take;
	logic [7:0] lo_addr;
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);
	// Config shadow
	always_ff @(posedge core_clk_in) begin
		if (reset_in)
			cfg_r <= CONFIG_RESET;
		else if (sfr_wr_in && sfr_addr_in == CONFIG_ADDR)
			cfg_r <= sfr_wdata_in;
	end
	// Decoded helpers
	assign mode = cfg_r[CFG_MODE_HI:CFG_MODE_LO];
	assign take = move_start_in && !move_busy_out;
	assign lo_addr = move_req_in.wide ? move_req_in.data_pointer[7:0] : move_req_in.indirect_low;

	release_idle_a: assert property (!move_busy_out |-> low_oe_out == 4'hf && high_oe_out == 4'hf)
		else $error("pins driven while idle");
	claim_in_move_a: assert property (low_bus_claim_out |-> move_busy_out)
		else $error("bus claimed outside a move");
	mode_pass_a: assert property (pin_output_mode_out == port_output_mode_in)
		else $error("pin output mode altered");
	onchip_quiet_a: assert property (move_busy_out && mode == 2'h0 |-> low_oe_out == 4'hf && high_oe_out == 4'hf)
		else $error("pin activity on on-chip move");
	onchip_done_a: assert property (take && mode == 2'h0 |-> ##3 move_done_out)
		else $error("on-chip move not done in 3 cycles");
	offchip_min_a: assert property (take && mode == 2'h3 |=> !move_done_out [*4])
		else $error("off-chip move too short");
	mux_min_a: assert property (take && mode == 2'h3 && !cfg_r[CFG_MUX_BIT] |=> !move_done_out [*6])
		else $error("multiplexed move too short");
	read_input_a: assert property (low_bus_claim_out && !low_pins_out.rd_n |-> low_oe_out.data_oe_n)
		else $error("data driven during read");
	upper_quiet_a: assert property (!cfg_r[CFG_BANK_BIT] |-> high_oe_out == 4'hf)
		else $error("upper bank driven");
	addr_high_a: assert property (low_bus_claim_out && !(low_pins_out.rd_n && low_pins_out.wr_n)
		|-> low_oe_out.addr_hi_oe_n == (!move_req_in.wide && mode != 2'h2))
		else $error("upper address drive wrong");
	ale_phase_a: assert property (low_bus_claim_out && low_pins_out.ale |-> low_pins_out.rd_n && low_pins_out.wr_n
		&& !low_oe_out.data_oe_n && low_pins_out.data == lo_addr)
		else $error("latch phase wrong");
endmodule

bind emi_core emi_core_props u_props (.core_clk_in(core_clk_in), .reset_in(reset_in), .sfr_wr_in(sfr_wr_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .move_start_in(move_start_in),
	.move_req_in(move_req_in), .move_busy_out(move_busy_out), .move_done_out(move_done_out),
	.port_output_mode_in(port_output_mode_in), .low_pins_out(low_pins_out), .low_oe_out(low_oe_out),
	.high_oe_out(high_oe_out), .pin_output_mode_out(pin_output_mode_out), .low_bus_claim_out(low_bus_claim_out));

// ==== emi_ext_mem.sv ====
// Purpose: Off-chip byte memory with address latch
// Assumes: Low address byte selects the location
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
module emi_ext_mem
	import emi_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       mux_in,
	input  wire emi_pins_t  pins_in,
	output logic      [7:0] data_out
);
	logic [7:0] mem [256];
	logic [7:0] lat_r;
	logic [7:0] last_r;
	logic [7:0] addr;
	// Address from latch or own pins
	assign addr = mux_in ? lat_r : pins_in.addr_lo;
	// Latch follows while enable high, holds after it falls
	always @(posedge core_clk_in) begin
		if (pins_in.ale)
			lat_r <= pins_in.data;
		if (!pins_in.wr_n)
			mem[addr] <= pins_in.data;
		if (!pins_in.rd_n)
			last_r <= mem[addr];
	end
	// Drive only in read strobe
	assign data_out = pins_in.rd_n ? ~last_r : mem[addr];
	initial begin
		lat_r = 8'h00;
		last_r = 8'h00;
		foreach (mem[i])
			mem[i] = 8'h00;
	end
endmodule

// ==== emi_onchip_data_ram.sv ====
// Purpose: On-chip data RAM of the external data space
// Assumes: Synchronous write, registered read
// Notes:   Address already wrapped to the RAM size
`timescale 1ns/1ps
module emi_onchip_data_ram
	import emi_pkg::*;
#(
	parameter int DEPTH = ONCHIP_DATA_RAM_BYTES,
	parameter int AW    = ONCHIP_DATA_RAM_AW
) (
	input  wire logic          core_clk_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [7:0]    wdata_in,
	output logic      [7:0]    rdata_out
);
	logic [7:0] mem_r [DEPTH];

	// Byte array, read-during-write returns old data
	always_ff @(posedge core_clk_in) begin
		if (we_in) begin
			mem_r[addr_in] <= wdata_in; // RULE_03
		end
		rdata_out <= mem_r[addr_in];
	end
endmodule

// ==== emi_pkg.sv ====
// Purpose: Shared constants and types for the external data memory interface
// Assumes: Single clock, synchronous active-high reset
// Notes:   Operation
// Operation
// (RULE_01) Register-form moves take high byte from page register, low byte from indirect register.
// (RULE_02) Pointer-form moves use the whole 16-bit data pointer as address.
// (RULE_03) Provide 8 k bytes of on-chip RAM in the external data space.
// (RULE_04) After reset, moves reach on-chip RAM until software picks another mode.
// (RULE_05) One bank select bit routes the bus to lower or upper port group.
// (RULE_06) Software sets crossbar skip so strobe and latch pins stay free.
// (RULE_07) Bus pins are claimed only during an off-chip move, then released.
// (RULE_08) Drivers of pins acting as inputs are disabled during a move.
// (RULE_09) Bus activity never changes the push-pull or open-drain pin mode.
// (RULE_10) Software presets port latches of bus pins to idle level, normally one.
// (RULE_11) Page value N selects addresses N*0x100 through N*0x100+0xFF.
// (RULE_12) A configuration bit selects multiplexed or non-multiplexed bus operation.
// (RULE_13) Multiplexed mode shares eight pins for low address and data.
// (RULE_14) Latch enable high with address, then low, then data with strobe.
// (RULE_15) External latch holds low address after latch enable falls.
// (RULE_16) Non-multiplexed mode uses separate address and data pins.
// (RULE_17) Mode 00 sends every move on-chip with normal addressing.
// (RULE_18) Internal-only mode wraps addresses modulo 8 k.
// (RULE_19) Mode 01 splits at 8 k; off-chip register moves leave upper address undriven.
// (RULE_20) Mode 10 splits at 8 k; off-chip register moves drive upper byte from page.
// (RULE_21) Mode 11 sends all moves off-chip; register moves ignore page, upper undriven.
// (RULE_22) Off-chip move lasts 4 cycles plus setup, strobe, hold; minimum 5 or 7.
// (RULE_23) On-chip accesses make no strobe, latch or address activity on the pins.
package emi_pkg;
	localparam int          ONCHIP_DATA_RAM_BYTES      = 8192;
	localparam int          ONCHIP_DATA_RAM_AW         = 13;
	localparam logic [7:0]  PAGE_SEL_ADDR   = 8'ha2;
	localparam logic [7:0]  TIMING_ADDR     = 8'ha1;
	localparam logic [7:0]  CONFIG_ADDR     = 8'ha3;
	localparam logic [7:0]  PAGE_RESET      = 8'h00;
	localparam logic [7:0]  TIMING_RESET    = 8'hff;
	localparam logic [7:0]  CONFIG_RESET    = 8'h03;
	// Config register fields
	localparam int          CFG_BANK_BIT    = 5;
	localparam int          CFG_MUX_BIT     = 4;
	localparam int          CFG_MODE_HI     = 3;
	localparam int          CFG_MODE_LO     = 2;
	localparam int          CFG_ALE_HI      = 1;
	localparam int          CFG_ALE_LO      = 0;
	// Timing register fields
	localparam int          TM_SETUP_HI     = 7;
	localparam int          TM_SETUP_LO     = 6;
	localparam int          TM_STRB_HI      = 5;
	localparam int          TM_STRB_LO      = 2;
	localparam int          TM_HOLD_HI      = 1;
	localparam int          TM_HOLD_LO      = 0;
	localparam logic [4:0]  BASE_CYCLES     = 5'h04;
	localparam logic [4:0]  ONE_CYCLE       = 5'h01;
	localparam logic [4:0]  ZERO_CYCLE      = 5'h00;

	typedef enum logic [1:0] {
		EMI_MODE_ONCHIP,
		EMI_MODE_SPLIT_NOBANK,
		EMI_MODE_SPLIT_BANK,
		EMI_MODE_OFFCHIP
	} emi_mode_t;

	// Move request from the core
	typedef struct packed {
		logic        wide;    // 1: data pointer form
		logic        write;
		logic [15:0] data_pointer;
		logic [7:0]  indirect_low;
		logic [7:0]  wdata;
	} emi_req_t;

	// Pin group for one port bank
	typedef struct packed {
		logic [7:0]  addr_hi;
		logic [7:0]  addr_lo;
		logic [7:0]  data;
		logic        ale;
		logic        rd_n;
		logic        wr_n;
	} emi_pins_t;

	// Output enables per pin group (low = driving)
	typedef struct packed {
		logic        addr_hi_oe_n;
		logic        addr_lo_oe_n;
		logic        data_oe_n;
		logic        ctrl_oe_n;
	} emi_oe_t;
endpackage

// ==== test_external_data_memory_interface.sv ====
// Purpose: Directed tests of registers, modes and moves
// Assumes: Inputs driven at falling edge
// Notes:   Zero timing setting keeps off-chip moves short
`timescale 1ns/1ps
module test_external_data_memory_interface
	import emi_pkg::*;
;
	logic       clk, rst, wr, start, busy, done, mux, bank;
	logic [7:0] addr, wdat, srd, mrd, dlo, dhi, pmo;
	emi_req_t   req;
	emi_pins_t  lo_p, hi_p;
	emi_oe_t    lo_oe, hi_oe;
	int         miscompares, n_compared, cyc;
	logic [7:0] cfgs [5] = '{8'h1c, 8'h0c, 8'h14, 8'h18, 8'h3c};
	int         mins [5] = '{5, 7, 5, 5, 5};

	emi_core dut (.core_clk_in(clk), .reset_in(rst), .sfr_wr_in(wr), .sfr_addr_in(addr), .sfr_wdata_in(wdat),
		.sfr_rdata_out(srd), .move_start_in(start), .move_req_in(req), .move_busy_out(busy),
		.move_done_out(done), .move_rdata_out(mrd), .port_latch_in('1), .data_pins_in(bank ? dhi : dlo),
		.port_output_mode_in(8'h5a), .low_pins_out(lo_p), .low_oe_out(lo_oe), .high_pins_out(hi_p),
		.high_oe_out(hi_oe), .pin_output_mode_out(pmo), .low_bus_claim_out());
	emi_ext_mem mem_lo (.core_clk_in(clk), .mux_in(mux), .pins_in(lo_p), .data_out(dlo));
	emi_ext_mem mem_hi (.core_clk_in(clk), .mux_in(mux), .pins_in(hi_p), .data_out(dhi));

	// Compare tasks
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_min(input int got, input int lim);
		n_compared++;
		if (got < lim) begin
			miscompares++;
			$display("Error at %0t: move took %0d cycles", $time, got);
		end
	endtask
	// Register access
	task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdat = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
		mux = (a == CONFIG_ADDR) ? !d[CFG_MUX_BIT] : mux;
		bank = (a == CONFIG_ADDR) ? d[CFG_BANK_BIT] : bank;
	endtask
	task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		#1;
		chk8(srd, exp);
	endtask
	// One move, counting cycles from take to done
	task automatic move(input logic wd, input logic w, input logic [15:0] dp, input logic [7:0] lo,
		input logic [7:0] d);
		@(negedge clk);
		req = '{wd, w, dp, lo, d};
		start = 1;
		@(negedge clk);
		start = 0;
		cyc = 1;
		while (done !== 1'b1 && cyc < 200) begin
			@(negedge clk);
			cyc++;
		end
		if (done !== 1'b1) begin
			miscompares++;
			$display("Error at %0t: move never completed", $time);
		end
	endtask
	task automatic wrap_up;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// Watchdog
	initial begin
		#(8 * 20000);
		miscompares++;
		wrap_up;
	end
	// Main sequence
	initial begin
		{rst, wr, start, mux, bank} = 5'h12;
		{addr, wdat} = 16'h0000;
		req = '0;
		repeat (16) @(negedge clk);
		rst = 0;
		sfr_r(PAGE_SEL_ADDR, 8'h00);
		sfr_r(CONFIG_ADDR, CONFIG_RESET);
		sfr_r(8'h55, 8'h00);
		sfr_r(TIMING_ADDR, TIMING_RESET);
		sfr_w(TIMING_ADDR, 8'h00);
		sfr_r(TIMING_ADDR, 8'h00);
		move(1, 1, 16'h1234, 8'h00, 8'h5a);
		chk8(8'(cyc), 8'h03);
		chk8(pmo, 8'h5a);
		sfr_w(PAGE_SEL_ADDR, 8'h12);
		sfr_r(PAGE_SEL_ADDR, 8'h12);
		move(0, 0, 16'h0000, 8'h34, 8'h00);
		chk8(mrd, 8'h5a);
		move(1, 1, 16'h2000, 8'h00, 8'h77);
		move(1, 0, 16'h4000, 8'h00, 8'h00);
		chk8(mrd, 8'h77);
		move(1, 1, 16'h1fff, 8'h00, 8'hc3);
		move(1, 0, 16'h3fff, 8'h00, 8'h00);
		chk8(mrd, 8'hc3);
		// Off-chip modes: pointer write, register-form read back
		sfr_w(PAGE_SEL_ADDR, 8'h20);
		for (int i = 0; i < 5; i++) begin
			sfr_w(CONFIG_ADDR, cfgs[i]);
			move(1, 1, {8'h20, 8'(16 * i + 16)}, 8'h00, 8'(8'h31 + i));
			chk_min(cyc, mins[i]);
			chk8(8'(cyc), 8'(mins[i] + 1));
			move(0, 0, 16'h0000, 8'(16 * i + 16), 8'h00);
			chk8(mrd, 8'(8'h31 + i));
		end
		sfr_w(CONFIG_ADDR, 8'h18);
		move(1, 0, 16'h1234, 8'h00, 8'h00);
		chk8(mrd, 8'h5a);
		sfr_w(CONFIG_ADDR, 8'h1c);
		move(1, 0, 16'h1234, 8'h00, 8'h00);
		chk8(mrd, 8'h00);
		wrap_up;
	end
endmodule
